// ==== verilog/spisfd_map.vh ====
// Field widths, idle levels and reset values of the SPI frame/select/DMA/stall core.
// Included by the core and its pin synchroniser; holds definitions only.
`ifndef SPISFD_MAP_VH
`define SPISFD_MAP_VH

`define SPISFD_DATA_W    16
`define SPISFD_LEN_W     4
`define SPISFD_SEL_W     4
`define SPISFD_DIV_W     16
`define SPISFD_DLY_W     4
`define SPISFD_EDGE_W    5
`define SPISFD_CNT_W     5
`define SPISFD_SEL_IDLE  4'hF
`define SPISFD_SEL_ONE   4'hE
`define SPISFD_DATA_RST  16'h0000
`define SPISFD_DIV_RST   16'h0000
`define SPISFD_PIN_W     7

`endif

// ==== verilog/spisfd_sync.v ====
// Three-stage pin synchroniser with agreement filter for the SPI core.
// Assumes asynchronous pin levels; output follows once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
`include "spisfd_map.vh"

module spisfd_sync (
  input  wire                     core_clk,
  input  wire                     arst_n,
  input  wire [`SPISFD_PIN_W-1:0] pin_in,
  output reg  [`SPISFD_PIN_W-1:0] pin_out
);

  reg [`SPISFD_PIN_W-1:0] stage1;
  reg [`SPISFD_PIN_W-1:0] stage2;
  reg [`SPISFD_PIN_W-1:0] stage3;
  integer i;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1  <= {`SPISFD_PIN_W{1'b1}};
      stage2  <= {`SPISFD_PIN_W{1'b1}};
      stage3  <= {`SPISFD_PIN_W{1'b1}};
      pin_out <= {`SPISFD_PIN_W{1'b1}};
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      for (i = 0; i < `SPISFD_PIN_W; i = i + 1) begin
        if (stage2[i] == stage3[i]) begin
          pin_out[i] <= stage3[i];
        end
      end
    end
  end

endmodule // spisfd_sync
`default_nettype wire

// ==== verilog/spisfd_core.v ====
// SPI master/slave core: rate divider, frame delays, four slave selects,
// DMA requests and master data stalls.
// Assumes one clock, single-word transmit and receive buffers written and read by strobes.
`timescale 1ns/1ps
`default_nettype none
`include "spisfd_map.vh"

// Summary of operation
// - Hold selects deasserted for transfer gap, two ticks minimum.
// - Slave shifting follows incoming SCK, no divider.
// - Master SCK comes straight from rate divider.
// - Divider is integer, divide-by-one allowed.
// - Divide value is minus-one encoded.
// - Four selects, per-line polarity, direction by mode.
// - Selects are active low inside; inversion at edge.
// - Slave active when any connected select asserted.
// - Master drives connected selects; at least one asserted transferring.
// - Select field written by control or data word.
// - Slave stores select state with each word.
// - DMA request per direction, acknowledge clears it.
// - Transmit request when enabled and buffer free.
// - Receive request when enabled and word waiting.
// - Frames of one to sixteen bits natively.
// - Modes 0/2 stall before final edge lacking data.
// - Modes 0/2 receive stall one edge earlier.
// - Modes 1/3 stall only against receive overrun.
// - Stalled flag shows a held edge, registered one clock late.
// - Polarity and phase pick the four SPI modes.
// - Master inserts frame delay after end-of-frame word unless it also ends the transfer.
// - Master waits pre-delay and post-delay around data.
module spisfd_core (
  input  wire                      core_clk,
  input  wire                      arst_n,
  input  wire                      mode_master,
  input  wire                      cpol,
  input  wire                      cpha,
  input  wire [`SPISFD_DIV_W-1:0]  rate_divide_value,
  input  wire [`SPISFD_DLY_W-1:0]  pre_delay,
  input  wire [`SPISFD_DLY_W-1:0]  post_delay,
  input  wire [`SPISFD_DLY_W-1:0]  frame_delay,
  input  wire [`SPISFD_DLY_W-1:0]  transfer_delay,
  input  wire [`SPISFD_SEL_W-1:0]  select_invert,
  input  wire [`SPISFD_SEL_W-1:0]  select_connected,
  input  wire                      tx_dma_en,
  input  wire                      rx_dma_en,
  input  wire                      control_reg_wr,
  input  wire [`SPISFD_SEL_W-1:0]  control_reg_select,
  input  wire                      tx_wr,
  input  wire [`SPISFD_DATA_W-1:0] tx_data,
  input  wire [`SPISFD_LEN_W-1:0]  tx_len,
  input  wire                      tx_end_of_frame,
  input  wire                      tx_end_of_transfer_flag,
  input  wire [`SPISFD_SEL_W-1:0]  tx_select,
  input  wire                      rx_rd,
  input  wire                      dma_tx_ack,
  input  wire                      dma_rx_ack,
  input  wire                      sck_in,
  input  wire                      mosi_in,
  input  wire                      miso_in,
  input  wire [`SPISFD_SEL_W-1:0]  ssel_in,
  output reg                       tx_ready,
  output reg                       rx_ready,
  output reg  [`SPISFD_DATA_W-1:0] receive_data_reg,
  output reg  [`SPISFD_SEL_W-1:0]  captured_select_state,
  output reg                       stalled,
  output reg                       dma_tx_req,
  output reg                       dma_rx_req,
  output reg                       sck_out,
  output reg                       sck_oe,
  output reg                       mosi_out,
  output reg                       mosi_oe,
  output reg                       miso_out,
  output reg                       miso_oe,
  output reg  [`SPISFD_SEL_W-1:0]  ssel_out,
  output reg  [`SPISFD_SEL_W-1:0]  ssel_oe
);

  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_PRE   = 7'h02;
  localparam [6:0] ST_XFER  = 7'h04;
  localparam [6:0] ST_POST  = 7'h08;
  localparam [6:0] ST_FRAME = 7'h10;
  localparam [6:0] ST_GAP   = 7'h20;
  localparam [6:0] ST_WAIT  = 7'h40;

  reg  [6:0]                state;
  reg  [`SPISFD_DIV_W-1:0]  div_cnt;
  reg  [`SPISFD_CNT_W-1:0]  dly_cnt;
  reg  [`SPISFD_EDGE_W-1:0] edge_idx;
  reg                       tx_full;
  reg  [`SPISFD_DATA_W-1:0] tx_buf;
  reg  [`SPISFD_LEN_W-1:0]  tx_len_buf;
  reg                       tx_eof_buf;
  reg                       tx_eot_buf;
  reg  [`SPISFD_SEL_W-1:0]  tx_sel_buf;
  reg  [`SPISFD_DATA_W-1:0] tx_shift;
  reg  [`SPISFD_DATA_W-1:0] rx_shift;
  reg  [`SPISFD_LEN_W-1:0]  cur_len;
  reg                       cur_eof;
  reg                       cur_eot;
  reg  [`SPISFD_SEL_W-1:0]  master_select_field;
  reg                       rx_full;
  reg                       sck_prev;
  reg                       slave_active_d;
  reg  [`SPISFD_LEN_W-1:0]  slave_cnt;

  wire [`SPISFD_PIN_W-1:0]  pins_sync;
  wire                      sck_s  = pins_sync[0];
  wire                      mosi_s = pins_sync[1];
  wire                      miso_s = pins_sync[2];
  wire [`SPISFD_SEL_W-1:0]  ssel_internal = pins_sync[6:3] ^ select_invert;
  wire slave_active = ~mode_master & (|(~ssel_internal & select_connected));

  // Places the word's MSB at bit 15 so the serial output is always bit 15.
  function [`SPISFD_DATA_W-1:0] align_word;
    input [`SPISFD_DATA_W-1:0] data;
    input [`SPISFD_LEN_W-1:0]  len;
    begin
      align_word = data << (4'hF - len);
    end
  endfunction

  spisfd_sync u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pin_in   ({ssel_in, miso_in, mosi_in, sck_in}),
    .pin_out  (pins_sync)
  );

  wire tick       = (div_cnt == rate_divide_value);
  wire last_edge  = (edge_idx == {cur_len, 1'b1});
  wire rxs_edge   = cpha ? last_edge : (edge_idx == {cur_len, 1'b0});
  wire leading    = ~edge_idx[0];
  wire tx_stall   = ~cpha & last_edge & ~cur_eot & ~cur_eof & ~tx_full;
  wire rx_stall   = rxs_edge & rx_full;
  wire stall_cond = (state == ST_XFER) & (tx_stall | rx_stall);
  wire m_sample   = leading ^ cpha;
  wire [`SPISFD_DATA_W-1:0] m_rx_next = m_sample ? {rx_shift[14:0], miso_s} : rx_shift;
  wire [`SPISFD_DATA_W-1:0] tx_aligned = align_word(tx_buf, tx_len_buf);
  wire s_change   = (sck_s != sck_prev);
  wire s_lead     = s_change & (sck_s != cpol);
  wire s_trail    = s_change & (sck_s == cpol);
  wire s_sample   = cpha ? s_trail : s_lead;
  wire s_drive    = cpha ? s_lead : s_trail;
  wire s_store    = slave_active & s_sample & (slave_cnt == tx_len_buf);
  wire m_store    = (state == ST_XFER) & tick & ~stall_cond & last_edge;
  wire load_now   = (state == ST_PRE) & tick & (dly_cnt == {1'b0, pre_delay});
  wire m_next_go  = tx_full & ((m_store & ~cur_eot & ~cur_eof) | (state == ST_WAIT));
  wire frame_done = (state == ST_FRAME) & tick & (dly_cnt == {1'b0, frame_delay});
  wire m_load     = load_now | m_next_go | (frame_done & tx_full);
  wire s_load     = (slave_active & ~slave_active_d) | s_store;
  wire tx_take    = m_load | (s_load & tx_full);
  wire next_tx_full = tx_wr | (tx_full & ~tx_take);
  wire next_rx_full = m_store | s_store | (rx_full & ~rx_rd);
  wire [`SPISFD_SEL_W-1:0] sel_load = (tx_sel_buf == `SPISFD_SEL_IDLE) ?
                                      `SPISFD_SEL_ONE : tx_sel_buf;

  // Transmit and receive buffers; a new word wins over a same-cycle take or read.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_full               <= 1'b0;
      tx_buf                <= `SPISFD_DATA_RST;
      tx_len_buf            <= {`SPISFD_LEN_W{1'b0}};
      tx_eof_buf            <= 1'b0;
      tx_eot_buf            <= 1'b0;
      tx_sel_buf            <= `SPISFD_SEL_IDLE;
      rx_full               <= 1'b0;
      receive_data_reg      <= `SPISFD_DATA_RST;
      captured_select_state <= `SPISFD_SEL_IDLE;
      tx_ready              <= 1'b0;
      rx_ready              <= 1'b0;
      dma_tx_req            <= 1'b0;
      dma_rx_req            <= 1'b0;
    end else begin
      tx_full  <= next_tx_full;
      rx_full  <= next_rx_full;
      tx_ready <= ~next_tx_full;
      rx_ready <= next_rx_full;
      if (tx_wr) begin
        tx_buf     <= tx_data;
        tx_len_buf <= tx_len;
        tx_eof_buf <= tx_end_of_frame;
        tx_eot_buf <= tx_end_of_transfer_flag;
        tx_sel_buf <= tx_select;
      end
      if (m_store) begin
        receive_data_reg      <= m_rx_next;
        captured_select_state <= master_select_field;
      end else if (s_store) begin
        receive_data_reg      <= {rx_shift[14:0], mosi_s};
        captured_select_state <= ssel_internal;
      end
      dma_tx_req <= ~dma_tx_ack & tx_dma_en & ~next_tx_full;
      dma_rx_req <= ~dma_rx_ack & rx_dma_en & next_rx_full;
    end
  end

  // Master sequencer, shared shift registers and slave bit engine.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state               <= ST_IDLE;
      div_cnt             <= `SPISFD_DIV_RST;
      dly_cnt             <= {`SPISFD_CNT_W{1'b0}};
      edge_idx            <= {`SPISFD_EDGE_W{1'b0}};
      tx_shift            <= `SPISFD_DATA_RST;
      rx_shift            <= `SPISFD_DATA_RST;
      cur_len             <= {`SPISFD_LEN_W{1'b0}};
      cur_eof             <= 1'b0;
      cur_eot             <= 1'b0;
      master_select_field <= `SPISFD_SEL_IDLE;
      stalled             <= 1'b0;
      sck_out             <= 1'b0;
      mosi_out            <= 1'b0;
      miso_out            <= 1'b0;
      sck_prev            <= 1'b1;
      slave_active_d      <= 1'b0;
      slave_cnt           <= {`SPISFD_LEN_W{1'b0}};
    end else begin
      sck_prev       <= sck_s;
      slave_active_d <= slave_active;
      stalled        <= stall_cond & tick;
      if (control_reg_wr) begin
        master_select_field <= control_reg_select;
      end
      if (!mode_master) begin
        state    <= ST_IDLE;
        div_cnt  <= `SPISFD_DIV_RST;
        edge_idx <= {`SPISFD_EDGE_W{1'b0}};
        sck_out  <= cpol;
        // Slave engine runs on select assertion and on edges of the incoming clock.
        if (!slave_active) begin
          slave_cnt <= {`SPISFD_LEN_W{1'b0}};
        end else if (s_load) begin
          if (!slave_active_d) begin
            rx_shift <= `SPISFD_DATA_RST;
            if (!cpha) begin
              miso_out <= tx_aligned[15];
              tx_shift <= tx_full ? (tx_aligned << 1) : `SPISFD_DATA_RST;
            end else begin
              tx_shift <= tx_full ? tx_aligned : `SPISFD_DATA_RST;
            end
          end else begin
            // A word boundary: store happened, next word starts.
            rx_shift  <= `SPISFD_DATA_RST;
            slave_cnt <= {`SPISFD_LEN_W{1'b0}};
            tx_shift  <= tx_full ? tx_aligned : `SPISFD_DATA_RST;
          end
        end else begin
          if (s_sample) begin
            rx_shift  <= {rx_shift[14:0], mosi_s};
            slave_cnt <= slave_cnt + 4'h1;
          end
          if (s_drive) begin
            miso_out <= tx_shift[15];
            tx_shift <= {tx_shift[14:0], 1'b0};
          end
        end
      end else begin
        // A stalled tick holds the divider at its end count until the stall clears.
        if (state == ST_IDLE || state == ST_WAIT || (tick && !stall_cond)) begin
          div_cnt <= `SPISFD_DIV_RST;
        end else if (!tick) begin
          div_cnt <= div_cnt + 16'h0001;
        end
        case (state)
          ST_IDLE: begin
            sck_out <= cpol;
            dly_cnt <= {`SPISFD_CNT_W{1'b0}};
            if (tx_full) begin
              state <= ST_PRE;
              master_select_field <= sel_load;
            end
          end
          ST_PRE: begin
            if (tick) begin
              dly_cnt <= dly_cnt + 5'h01;
            end
            if (load_now) begin
              state <= ST_XFER;
            end
          end
          ST_XFER: begin
            if (tick && !stall_cond) begin
              // Held edge completes here once the stall condition clears.
              sck_out  <= ~sck_out;
              edge_idx <= edge_idx + 5'h01;
              if (m_sample) begin
                rx_shift <= m_rx_next;
              end
              if ((cpha && leading) || (!cpha && !leading && !last_edge)) begin
                mosi_out <= tx_shift[15];
                tx_shift <= {tx_shift[14:0], 1'b0};
              end
              if (last_edge) begin
                dly_cnt <= {`SPISFD_CNT_W{1'b0}};
                if (cur_eot) begin
                  state <= ST_POST;
                end else if (cur_eof) begin
                  state <= ST_FRAME;
                end else if (!tx_full) begin
                  state <= ST_WAIT;
                end
              end
            end
          end
          ST_WAIT: begin
            if (tx_full) begin
              state <= ST_XFER;
            end
          end
          ST_FRAME: begin
            if (tick) begin
              dly_cnt <= dly_cnt + 5'h01;
            end
            if (frame_done) begin
              state <= tx_full ? ST_XFER : ST_WAIT;
            end
          end
          ST_POST: begin
            if (tick) begin
              dly_cnt <= dly_cnt + 5'h01;
              if (dly_cnt == {1'b0, post_delay}) begin
                dly_cnt <= {`SPISFD_CNT_W{1'b0}};
                state   <= ST_GAP;
              end
            end
          end
          ST_GAP: begin
            if (tick) begin
              dly_cnt <= dly_cnt + 5'h01;
              if (dly_cnt == {transfer_delay, 1'b1}) begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
        // Loading comes last so a new word restarts its edge count.
        if (m_load) begin
          cur_len  <= tx_len_buf;
          cur_eof  <= tx_eof_buf;
          cur_eot  <= tx_eot_buf;
          edge_idx <= {`SPISFD_EDGE_W{1'b0}};
          rx_shift <= `SPISFD_DATA_RST;
          master_select_field <= sel_load;
          if (!cpha) begin
            mosi_out <= tx_aligned[15];
            tx_shift <= tx_aligned << 1;
          end else begin
            tx_shift <= tx_aligned;
          end
        end
      end
    end
  end

  // Pin drivers; select polarity is applied only here on the way out.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ssel_out <= `SPISFD_SEL_IDLE;
      ssel_oe  <= {`SPISFD_SEL_W{1'b0}};
      sck_oe   <= 1'b0;
      mosi_oe  <= 1'b0;
      miso_oe  <= 1'b0;
    end else begin
      if (state == ST_IDLE || state == ST_GAP) begin
        ssel_out <= `SPISFD_SEL_IDLE ^ select_invert;
      end else begin
        ssel_out <= master_select_field ^ select_invert;
      end
      ssel_oe <= {`SPISFD_SEL_W{mode_master}} & select_connected;
      sck_oe  <= mode_master;
      mosi_oe <= mode_master;
      miso_oe <= slave_active;
    end
  end

endmodule // spisfd_core
`default_nettype wire

// ==== verification/spisfd_props.sv ====
// Checker for the SPI core: DMA requests, select and clock levels, stalls.
// Sees only the core's ports; bound to every core instance below.
`timescale 1ns/1ps
`default_nettype none
module spisfd_props (
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic       mode_master,
  input wire logic       cpol,
  input wire logic       cpha,
  input wire logic [3:0] select_invert,
  input wire logic [3:0] select_connected,
  input wire logic       tx_dma_en,
  input wire logic       rx_dma_en,
  input wire logic       tx_wr,
  input wire logic       rx_rd,
  input wire logic       dma_tx_ack,
  input wire logic       dma_rx_ack,
  input wire logic       tx_ready,
  input wire logic       rx_ready,
  input wire logic       stalled,
  input wire logic       dma_tx_req,
  input wire logic       dma_rx_req,
  input wire logic       sck_out,
  input wire logic       sck_oe,
  input wire logic [3:0] ssel_out,
  input wire logic [3:0] ssel_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_desel;
    mode_master && $stable(cpol) && ((ssel_out ^ select_invert) == 4'hF);
  endsequence
  sequence s_sck_move;
    mode_master && $stable(cpol) ##1 $changed(sck_out) && $stable(cpol);
  endsequence
  property p_sck_rest; s_desel [*3] |-> sck_out == cpol; endproperty
  a_sck_rest: assert property (p_sck_rest) else $error("clock left rest while deselected");
  property p_one_sel; s_sck_move |-> (ssel_out ^ select_invert) != 4'hF; endproperty
  a_one_sel: assert property (p_one_sel) else $error("clock edge with no select");
  property p_oe;
    arst_n |=> sck_oe == $past(mode_master) && ssel_oe == ($past(select_connected)
      & {4{$past(mode_master)}});
  endproperty
  a_oe: assert property (p_oe) else $error("pin drive enables wrong");
  property p_tx_req; (tx_dma_en && tx_ready && !dma_tx_ack) [*2] |-> dma_tx_req; endproperty
  a_tx_req: assert property (p_tx_req) else $error("transmit request missing");
  property p_rx_req; (rx_dma_en && rx_ready && !dma_rx_ack) [*2] |-> dma_rx_req; endproperty
  a_rx_req: assert property (p_rx_req) else $error("receive request missing");
  property p_tx_ack; dma_tx_req && dma_tx_ack |=> !dma_tx_req; endproperty
  a_tx_ack: assert property (p_tx_ack) else $error("transmit request not cleared");
  property p_rx_ack; dma_rx_req && dma_rx_ack |=> !dma_rx_req; endproperty
  a_rx_ack: assert property (p_rx_ack) else $error("receive request not cleared");
  property p_no_req; (!tx_dma_en) [*2] |-> !dma_tx_req; endproperty
  a_no_req: assert property (p_no_req) else $error("transmit request while disabled");
  property p_stall_hold; stalled [*3] |-> $stable(sck_out); endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("clock moved while stalled");
  property p_stall_13; mode_master && cpha && stalled |-> rx_ready || $past(rx_ready); endproperty
  a_stall_13: assert property (p_stall_13) else $error("stall without waiting word");
  property p_rx_hold; rx_ready && !rx_rd |=> rx_ready; endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("receive flag dropped unread");
  property p_tx_take; tx_wr |=> !tx_ready; endproperty
  a_tx_take: assert property (p_tx_take) else $error("transmit flag stayed set");
endmodule // spisfd_props
bind spisfd_core spisfd_props u_spisfd_props (.core_clk, .arst_n, .mode_master, .cpol, .cpha,
  .select_invert, .select_connected, .tx_dma_en, .rx_dma_en, .tx_wr, .rx_rd, .dma_tx_ack,
  .dma_rx_ack, .tx_ready, .rx_ready, .stalled, .dma_tx_req, .dma_rx_req, .sck_out, .sck_oe,
  .ssel_out, .ssel_oe);
`default_nettype wire

// ==== verification/spisfd_slave_model.sv ====
// Echoing external SPI slave: loops MOSI back on MISO and records the last frame.
// Assumes resolved pin levels and a core clock much faster than SCK.
`timescale 1ns/1ps
`default_nettype none
module spisfd_slave_model (
  input  wire logic        core_clk,
  input  wire logic        cpol,
  input  wire logic        cpha,
  input  wire logic [3:0]  sel_inv,
  input  wire logic [3:0]  ssel_w,
  input  wire logic        sck_w,
  input  wire logic        mosi_w,
  output wire logic        miso_p,
  output wire logic        active,
  output var  logic [15:0] shreg,
  output var  logic [3:0]  sel_seen,
  output var  int          edges,
  output var  int          gap
);
  logic sck_q = 1'b0;
  logic act_q = 1'b0;
  logic tog = 1'b0;
  int   dcnt = 0;
  assign active = (ssel_w ^ sel_inv) != 4'hF;
  // A released line toggles so that a stale level is never read as data.
  assign miso_p = active ? mosi_w : tog;
  always @(posedge core_clk) begin
    tog <= ~tog;
    sck_q <= sck_w;
    act_q <= active;
    dcnt <= active ? 0 : dcnt + 1;
    if (active && !act_q) begin
      gap <= dcnt;
      edges <= 0;
      shreg <= 16'h0000;
      sel_seen <= ssel_w;
    end else if (active && sck_w != sck_q) begin
      edges <= edges + 1;
      // Modes 0 and 2 take data leaving rest, modes 1 and 3 on the return edge.
      if ((sck_w != cpol) != cpha) shreg <= {shreg[14:0], mosi_w};
    end
  end
endmodule // spisfd_slave_model
`default_nettype wire

// ==== verification/spi_frame_select_dma_stall_tb.sv ====
// Bench for the SPI core in master mode against an echoing slave model.
// Assumes the core, synchroniser, slave model and bound checker compile before it.
`timescale 1ns/1ps
`default_nettype none
module spi_frame_select_dma_stall_tb;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        cpol = 1'b0;
  logic        cpha = 1'b0;
  logic        tx_wr = 1'b0;
  logic        rx_rd = 1'b0;
  logic        tx_dma_en = 1'b0;
  logic        rx_dma_en = 1'b0;
  logic        dma_tx_ack = 1'b0;
  logic        dma_rx_ack = 1'b0;
  logic        tx_end_of_frame = 1'b0;
  logic        tx_end_of_transfer_flag = 1'b0;
  logic        tog = 1'b0;
  logic [15:0] rate_divide_value = 16'h0007;
  logic [15:0] tx_data = 16'h0000;
  logic [3:0]  tx_len = 4'h0;
  logic [3:0]  tx_select = 4'hF;
  logic [3:0]  pre_delay = 4'h0;
  logic [3:0]  post_delay = 4'h0;
  logic [3:0]  frame_delay = 4'h0;
  logic [3:0]  transfer_delay = 4'h0;
  logic [3:0]  select_invert = 4'h0;
  wire         tx_ready, rx_ready, stalled, dma_tx_req, dma_rx_req, sck_out, sck_oe;
  wire         mosi_out, mosi_oe, miso_out, miso_oe, miso_p, active, sck_w, mosi_w, miso_w;
  wire  [15:0] receive_data_reg, shreg;
  wire  [3:0]  captured_select_state, ssel_out, ssel_oe, ssel_w, sel_seen;
  int          edges, gap, error_cnt = 0, compares = 0, seed = 28500;
  int          exp_q[$];
  int          sel_q[$];
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) tog <= ~tog;
  // Undriven lines toggle; selects have pull-ups.
  assign sck_w = sck_oe ? sck_out : tog;
  assign mosi_w = mosi_oe ? mosi_out : tog;
  assign miso_w = miso_oe ? miso_out : miso_p;
  assign ssel_w = (ssel_oe & ssel_out) | ~ssel_oe;
  spisfd_core u_spisfd_core (
    .core_clk, .arst_n, .mode_master(1'b1), .cpol, .cpha, .rate_divide_value, .pre_delay,
    .post_delay, .frame_delay, .transfer_delay, .select_invert, .select_connected(4'hF),
    .tx_dma_en, .rx_dma_en, .control_reg_wr(1'b0), .control_reg_select(4'hF), .tx_wr,
    .tx_data, .tx_len, .tx_end_of_frame, .tx_end_of_transfer_flag, .tx_select, .rx_rd,
    .dma_tx_ack, .dma_rx_ack, .sck_in(sck_w), .mosi_in(mosi_w), .miso_in(miso_w),
    .ssel_in(ssel_w), .tx_ready, .rx_ready, .receive_data_reg, .captured_select_state,
    .stalled, .dma_tx_req, .dma_rx_req, .sck_out, .sck_oe, .mosi_out, .mosi_oe, .miso_out,
    .miso_oe, .ssel_out, .ssel_oe);
  spisfd_slave_model u_spisfd_slave_model (
    .core_clk, .cpol, .cpha, .sel_inv(select_invert), .ssel_w, .sck_w, .mosi_w, .miso_p,
    .active, .shreg, .sel_seen, .edges, .gap);
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic bit cond(input int k);
    case (k)
      0: return tx_ready === 1'b1;
      1: return rx_ready === 1'b1;
      2: return stalled === 1'b1;
      default: return active === 1'b0;
    endcase
  endfunction
  task automatic wait_for(input string what, input int k);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!cond(k) && n < 20000);
    if (!cond(k)) begin
      error_cnt++;
      $display("unexpected %s expected set seen clear", what);
      complete_run();
    end
  endtask
  task automatic wr(input int d, input int len, input bit eof, input bit end_of_transfer_flag, input int sel);
    wait_for("transmit ready", 0);
    tx_data <= d[15:0];
    tx_len <= len[3:0];
    tx_end_of_frame <= eof;
    tx_end_of_transfer_flag <= end_of_transfer_flag;
    tx_select <= sel[3:0];
    tx_wr <= 1'b1;
    @(posedge core_clk);
    tx_wr <= 1'b0;
    exp_q.push_back(d & ((1 << (len + 1)) - 1));
    sel_q.push_back((sel[3:0] == 4'hF) ? 14 : sel[3:0]);
  endtask
  task automatic rd();
    int e;
    wait_for("receive ready", 1);
    e = exp_q.pop_front();
    check("receive word", receive_data_reg, e[15:0]);
    check("receive request", 16'(dma_rx_req), 16'h0001);
    e = sel_q.pop_front();
    check("captured select", 16'(captured_select_state), e[15:0]);
    rx_rd <= 1'b1;
    dma_rx_ack <= 1'b1;
    @(posedge core_clk);
    rx_rd <= 1'b0;
    dma_rx_ack <= 1'b0;
  endtask
  initial begin
    int m, d0, d1, l0, l1, s1, dv, td;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("ready after reset", 16'(tx_ready), 16'h0001);
    check("idle select pins", 16'(ssel_out), 16'h000F);
    check("idle clock", 16'(sck_out), 16'h0000);
    $display("test reset done");
    tx_dma_en <= 1'b1;
    rx_dma_en <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("transmit request", 16'(dma_tx_req), 16'h0001);
    dma_tx_ack <= 1'b1;
    @(posedge core_clk);
    dma_tx_ack <= 1'b0;
    tx_dma_en <= 1'b0;
    @(posedge core_clk);
    check("request after ack", 16'(dma_tx_req), 16'h0000);
    $display("test dma done");
    for (m = 0; m < 4; m++) begin
      dv = 7 + ($random(seed) & 3);
      td = $random(seed) & 3;
      cpol <= m[1];
      cpha <= m[0];
      rate_divide_value <= 16'(dv);
      transfer_delay <= 4'(td);
      pre_delay <= 4'($random(seed));
      post_delay <= 4'($random(seed));
      frame_delay <= 4'($random(seed));
      select_invert <= 4'($random(seed));
      d0 = $random(seed);
      d1 = $random(seed);
      l0 = (m == 1) ? 0 : ($random(seed) & 15);
      l1 = (m == 0) ? 15 : ($random(seed) & 15);
      s1 = $random(seed) & 15;
      wr(d0, l0, 1'b1, 1'b1, $random(seed) & 15);
      wr(d1, l1, 1'b1, 1'b1, s1);
      rd();
      rd();
      wait_for("select release", 3);
      // Let the deselect gap run out before the mode changes.
      repeat (100) @(posedge core_clk);
      check("slave shift", shreg, 16'(d1 & ((1 << (l1 + 1)) - 1)));
      check("clock edges", 16'(edges), 16'(2 * (l1 + 1)));
      check("select pins", 16'(sel_seen), 16'(((s1 == 15) ? 14 : s1) ^ select_invert));
      check("deselect gap", 16'(gap >= (td + 1) * 2 * (dv + 1)), 16'h0001);
      $display("test mode %0d done", m);
    end
    cpol <= 1'b0;
    cpha <= 1'b0;
    wr(16'hA5C3, 7, 1'b0, 1'b0, 11);
    wait_for("transmit stall", 2);
    check("clock held high", 16'(sck_out), 16'h0001);
    wr(16'h3C5A, 7, 1'b1, 1'b1, 11);
    rd();
    rd();
    $display("test transmit stall done");
    wait_for("select release", 3);
    repeat (100) @(posedge core_clk);
    cpol <= 1'b1;
    cpha <= 1'b1;
    wr(16'h1234, 9, 1'b1, 1'b0, 5);
    wr(16'h0F0F, 9, 1'b1, 1'b1, 5);
    wait_for("receive stall", 2);
    check("word waiting", 16'(rx_ready), 16'h0001);
    check("clock held low", 16'(sck_out), 16'h0000);
    rd();
    rd();
    $display("test receive stall done");
    complete_run();
  end
endmodule // spi_frame_select_dma_stall_tb
`default_nettype wire
